// ### hw/stap_params.svh
`ifndef STAP_PARAMS_SVH
`define STAP_PARAMS_SVH

// instruction register geometry and opcodes
`define STAP_IR_LEN 3
`define STAP_OP_EXTEST 3'h0
`define STAP_OP_IDCODE 3'h1
`define STAP_OP_SAMPLE_Z 3'h2
`define STAP_OP_RSVD_A 3'h3
`define STAP_OP_SAMPLE 3'h4
`define STAP_OP_RSVD_B 3'h5
`define STAP_OP_RSVD_C 3'h6
`define STAP_OP_BYPASS 3'h7

// fixed capture pattern of the two low instruction bits
`define STAP_IR_CAPTURE 2'h1
// upper instruction bit captured alongside the pattern
`define STAP_IR_CAPTURE_MSB 1'h0

// data registers
`define STAP_ID_LEN 32
// arbitrary identification value, bit 0 set as the scan standard expects
`define STAP_ID_CODE 32'h0A5C_3001
`define STAP_BSR_LEN 64
`define STAP_OE_CELL 47
`define STAP_BYPASS_CAPTURE 1'h0

// consecutive high mode-select samples that force the reset state
`define STAP_RESET_EDGES 5

`endif

// ### hw/stap_pkg.sv
package stap_pkg;

	typedef enum logic [3:0] {
		st_reset,
		st_idle,
		st_sel_dr,
		st_cap_dr,
		st_sh_dr,
		st_ex1_dr,
		st_pause_dr,
		st_ex2_dr,
		st_upd_dr,
		st_sel_ir,
		st_cap_ir,
		st_sh_ir,
		st_ex1_ir,
		st_pause_ir,
		st_ex2_ir,
		st_upd_ir
	} stap_state_type;

endpackage

// ### hw/stap_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser; only the second stage is visible
module stap_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end

endmodule

// ### hw/stap_top.sv
`timescale 1ns/1ns
`include "stap_params.svh"

// Overview of operation
// [RQ1] inputs sampled on rising test clock, outputs change on falling edge
// [RQ2] mode select pulled high at the pad, sampled each rising test edge
// [RQ3] serial input enters the selected register MSB, output leaves its LSB
// [RQ4] serial output driven only in shift states, updated on falling edges
// [RQ5] five rising edges with mode select high return the controller to reset
// [RQ6] controller reset leaves memory operation untouched
// [RQ7] power-up resets the controller, serial output starts undriven
// [RQ8] unused port: tester holds test clock low, output left open
// [RQ9] exactly one data register in the scan path, chosen by instruction
// [RQ10] three-bit instruction register, loaded serially while in the path
// [RQ11] reset state loads the identification instruction
// [RQ12] instruction capture loads 01 into the two low bits
// [RQ13] single-bit bypass register, cleared to zero when bypass executes
// [RQ14] boundary register covers the pin ring, captures then shifts
// [RQ15] extest, sample/preload and sample-z capture the pin ring
// [RQ16] identification instruction captures the fixed 32-bit code and shifts it
// [RQ17] cell 47 enables the read bus under extest, presets high on reset
// [RQ18] sample-z keeps the read bus undriven until the next instruction update
// [RQ19] three opcodes reserved; tester never loads them
// [RQ20] standard sixteen-state controller advancing on rising test clock
// [RQ21] new instruction takes effect only in instruction update
module stap_top import stap_pkg::*; #(
	parameter int BSR_LEN = `STAP_BSR_LEN,
	parameter logic [`STAP_ID_LEN-1:0] ID_CODE = `STAP_ID_CODE
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo_out,
	output logic tdo_oe_n,
	input wire logic [BSR_LEN-1:0] pin_ring_in,
	output logic ext_drive,
	output logic [BSR_LEN-1:0] ext_data,
	output logic qbus_oe
);

	localparam int IRW = `STAP_IR_LEN;
	localparam int IDW = `STAP_ID_LEN;
	localparam int OEC = `STAP_OE_CELL;
	localparam logic [BSR_LEN-1:0] UPD_RST =
		BSR_LEN'(1) << OEC;
	localparam logic [BSR_LEN+1:0] CTL_RST = {1'b1, 1'b0, UPD_RST};

	function automatic logic sel_bsr(input logic [IRW-1:0] op);
		sel_bsr = (op == `STAP_OP_EXTEST) || (op == `STAP_OP_SAMPLE) ||
			(op == `STAP_OP_SAMPLE_Z);
	endfunction

	function automatic logic sel_id(input logic [IRW-1:0] op);
		sel_id = (op == `STAP_OP_IDCODE);
	endfunction

	// reset release, one copy per clock domain
	logic [1:0] rst_clk_ff;
	logic [1:0] rst_tck_ff;
	logic rst_clk_n;
	logic rst_tck_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_clk_ff <= 2'h0;
		end else begin
			rst_clk_ff <= {rst_clk_ff[0], 1'b1};
		end
	end

	// [RQ7] power-up reset
	always_ff @(posedge tck or negedge nrst) begin
		if (!nrst) begin
			rst_tck_ff <= 2'h0;
		end else begin
			rst_tck_ff <= {rst_tck_ff[0], 1'b1};
		end
	end

	assign rst_clk_n = rst_clk_ff[1];
	assign rst_tck_n = rst_tck_ff[1];

	// controller state
	stap_state_type state_ff;
	stap_state_type nxt_state;

	// [RQ20] [RQ5] sixteen-state walk, five highs reach reset
	always_comb begin
		case (state_ff)
		st_reset: nxt_state = tms ? st_reset : st_idle;
		st_idle: nxt_state = tms ? st_sel_dr : st_idle;
		st_sel_dr: nxt_state = tms ? st_sel_ir : st_cap_dr;
		st_cap_dr: nxt_state = tms ? st_ex1_dr : st_sh_dr;
		st_sh_dr: nxt_state = tms ? st_ex1_dr : st_sh_dr;
		st_ex1_dr: nxt_state = tms ? st_upd_dr : st_pause_dr;
		st_pause_dr: nxt_state = tms ? st_ex2_dr : st_pause_dr;
		st_ex2_dr: nxt_state = tms ? st_upd_dr : st_sh_dr;
		st_upd_dr: nxt_state = tms ? st_sel_dr : st_idle;
		st_sel_ir: nxt_state = tms ? st_reset : st_cap_ir;
		st_cap_ir: nxt_state = tms ? st_ex1_ir : st_sh_ir;
		st_sh_ir: nxt_state = tms ? st_ex1_ir : st_sh_ir;
		st_ex1_ir: nxt_state = tms ? st_upd_ir : st_pause_ir;
		st_pause_ir: nxt_state = tms ? st_ex2_ir : st_pause_ir;
		st_ex2_ir: nxt_state = tms ? st_upd_ir : st_sh_ir;
		st_upd_ir: nxt_state = tms ? st_sel_dr : st_idle;
		default: nxt_state = st_reset;
		endcase
	end

	// [RQ2] mode select sampled on every rising edge
	always_ff @(posedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			state_ff <= st_reset;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// state decodes
	wire in_reset = (state_ff == st_reset);
	wire cap_ir = (state_ff == st_cap_ir);
	wire sh_ir = (state_ff == st_sh_ir);
	wire upd_ir = (state_ff == st_upd_ir);
	wire cap_dr = (state_ff == st_cap_dr);
	wire sh_dr = (state_ff == st_sh_dr);
	wire upd_dr = (state_ff == st_upd_dr);

	// instruction register
	logic [IRW-1:0] ir_sh_ff;
	logic [IRW-1:0] ir_ff;

	// [RQ12] capture pattern for chain fault isolation
	// [RQ10] serial load while in the path
	always_ff @(posedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			ir_sh_ff <= `STAP_OP_IDCODE;
		end else if (cap_ir) begin
			ir_sh_ff <= {`STAP_IR_CAPTURE_MSB, `STAP_IR_CAPTURE};
		end else if (sh_ir) begin
			ir_sh_ff <= {tdi, ir_sh_ff[IRW-1:1]};
		end
	end

	// [RQ11] identification is the default instruction
	// [RQ21] only instruction update and the reset state change the active code
	always_ff @(posedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			ir_ff <= `STAP_OP_IDCODE;
		end else if (in_reset) begin
			ir_ff <= `STAP_OP_IDCODE;
		end else if (upd_ir) begin
			ir_ff <= ir_sh_ff;
		end
	end

	// [RQ9] [RQ19] one data register; reserved codes act as bypass
	wire use_bsr = sel_bsr(ir_ff);
	wire use_id = sel_id(ir_ff);
	wire use_byp = !use_bsr && !use_id;

	// pin ring brought onto the test clock
	logic [BSR_LEN-1:0] ring_tck;

	stap_sync #(
		.WIDTH(BSR_LEN),
		.RST_VAL('0)
	) u_ring_sync (
		.clk(tck),
		.rst_n(rst_tck_n),
		.d(pin_ring_in),
		.q(ring_tck)
	);

	// data registers
	logic byp_ff;
	logic [IDW-1:0] id_sh_ff;
	logic [BSR_LEN-1:0] bsr_sh_ff;
	logic [BSR_LEN-1:0] bsr_upd_ff;

	// [RQ13] bypass cleared on capture, one cell in the path
	always_ff @(posedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			byp_ff <= `STAP_BYPASS_CAPTURE;
		end else if (use_byp && cap_dr) begin
			byp_ff <= `STAP_BYPASS_CAPTURE;
		end else if (use_byp && sh_dr) begin
			byp_ff <= tdi;
		end
	end

	// [RQ16] fixed code captured then shifted
	always_ff @(posedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			id_sh_ff <= '0;
		end else if (use_id && cap_dr) begin
			id_sh_ff <= ID_CODE;
		end else if (use_id && sh_dr) begin
			id_sh_ff <= {tdi, id_sh_ff[IDW-1:1]};
		end
	end

	// [RQ14] pin ring captured, then shifted
	// [RQ15] all three boundary instructions capture
	// [RQ3] serial input enters at the MSB
	always_ff @(posedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			bsr_sh_ff <= '0;
		end else if (use_bsr && cap_dr) begin
			bsr_sh_ff <= ring_tck;
		end else if (use_bsr && sh_dr) begin
			bsr_sh_ff <= {tdi, bsr_sh_ff[BSR_LEN-1:1]};
		end
	end

	// [RQ17] enable cell presets high on every controller reset
	always_ff @(posedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			bsr_upd_ff <= UPD_RST;
		end else if (in_reset) begin
			bsr_upd_ff <= UPD_RST;
		end else if (use_bsr && upd_dr) begin
			bsr_upd_ff <= bsr_sh_ff;
		end
	end

	// [RQ3] serial output from the LSB of the selected register
	wire dr_lsb = use_bsr ? bsr_sh_ff[0] :
		(use_id ? id_sh_ff[0] : byp_ff);
	wire tdo_src = sh_ir ? ir_sh_ff[0] : dr_lsb;
	wire tdo_drive = sh_ir || sh_dr;

	// [RQ1] outputs move on the falling edge
	// [RQ4] driven only in the shift states
	always_ff @(negedge tck or negedge rst_tck_n) begin
		if (!rst_tck_n) begin
			tdo_out <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else begin
			tdo_out <= tdo_src;
			tdo_oe_n <= !tdo_drive;
		end
	end

	// [RQ17] extest hands the read bus to cell 47
	// [RQ18] sample-z floats the read bus until the next update
	// [RQ6] reset restores identification, so memory runs normally
	wire ext_tck = (ir_ff == `STAP_OP_EXTEST);
	wire qoe_tck = ext_tck ? bsr_upd_ff[OEC] :
		(ir_ff != `STAP_OP_SAMPLE_Z);

	// quasi-static words: they change only on an update state or in the reset state, so a
	// few clk cycles of skew between bits is the accepted trade-off
	logic [BSR_LEN+1:0] ctl_clk;

	stap_sync #(
		.WIDTH(BSR_LEN + 2),
		.RST_VAL(CTL_RST)
	) u_ctl_sync (
		.clk(clk),
		.rst_n(rst_clk_n),
		.d({qoe_tck, ext_tck, bsr_upd_ff}),
		.q(ctl_clk)
	);

	// memory-side outputs registered once more in the core domain
	always_ff @(posedge clk or negedge rst_clk_n) begin
		if (!rst_clk_n) begin
			qbus_oe <= 1'b1;
			ext_drive <= 1'b0;
			ext_data <= UPD_RST;
		end else begin
			qbus_oe <= ctl_clk[BSR_LEN+1];
			ext_drive <= ctl_clk[BSR_LEN];
			ext_data <= ctl_clk[BSR_LEN-1:0];
		end
	end

	// checks on the test clock; chk_qbus_follow runs on the core clock

	chk_tms_reset: assert property ( // [RQ5]
		@(posedge tck) disable iff (!rst_tck_n)
		tms [*5] |=> (state_ff == st_reset))
		else $error("five high mode samples did not reach reset");

	chk_capir_pattern: assert property ( // [RQ12]
		@(posedge tck) disable iff (!rst_tck_n)
		cap_ir |=> (ir_sh_ff[1:0] == 2'h1))
		else $error("instruction capture pattern wrong");

	chk_reset_idcode: assert property ( // [RQ11]
		@(posedge tck) disable iff (!rst_tck_n)
		in_reset |=> (ir_ff == `STAP_OP_IDCODE))
		else $error("reset did not load identification");

	chk_ir_hold: assert property ( // [RQ21]
		@(posedge tck) disable iff (!rst_tck_n)
		(!upd_ir && !in_reset) |=> $stable(ir_ff))
		else $error("active instruction changed outside update");

	chk_ir_update: assert property ( // [RQ10]
		@(posedge tck) disable iff (!rst_tck_n)
		upd_ir |=> (ir_ff == $past(ir_sh_ff)))
		else $error("update did not take shifted instruction");

	chk_bypass_clear: assert property ( // [RQ13]
		@(posedge tck) disable iff (!rst_tck_n)
		(cap_dr && use_byp) |=> (byp_ff == 1'b0))
		else $error("bypass not cleared on capture");

	chk_id_capture: assert property ( // [RQ16]
		@(posedge tck) disable iff (!rst_tck_n)
		(cap_dr && use_id) ##1 (sh_dr && use_id) |=>
		(id_sh_ff[IDW-2:0] == ID_CODE[IDW-1:1]))
		else $error("identification code not shifted");

	chk_bsr_msb_in: assert property ( // [RQ3]
		@(posedge tck) disable iff (!rst_tck_n)
		(sh_dr && use_bsr) |=> (bsr_sh_ff[BSR_LEN-1] == $past(tdi)))
		else $error("serial input not at boundary msb");

	chk_bsr_capture: assert property ( // [RQ15]
		@(posedge tck) disable iff (!rst_tck_n)
		(cap_dr && use_bsr) |=> (bsr_sh_ff == $past(ring_tck)))
		else $error("pin ring not captured");

	chk_tdo_window: assert property ( // [RQ4]
		@(posedge tck) disable iff (!rst_tck_n)
		!tdo_oe_n |-> (sh_ir || sh_dr))
		else $error("serial output driven outside shift");

	chk_one_path: assert property ( // [RQ9]
		@(posedge tck) disable iff (!rst_tck_n)
		$onehot({use_bsr, use_id, use_byp}))
		else $error("not exactly one data register selected");

	chk_cell_preset: assert property ( // [RQ17]
		@(posedge tck) disable iff (!rst_tck_n)
		in_reset |=> bsr_upd_ff[OEC])
		else $error("enable cell not preset on reset");

	chk_samplez_float: assert property ( // [RQ18]
		@(posedge tck) disable iff (!rst_tck_n)
		(ir_ff == `STAP_OP_SAMPLE_Z) |-> !qoe_tck)
		else $error("read bus enabled under sample-z");

	chk_qbus_follow: assert property ( // [RQ17]
		@(posedge clk) disable iff (!rst_clk_n)
		(ctl_clk[BSR_LEN] && $stable(ctl_clk)) |=>
		(qbus_oe == $past(ctl_clk[OEC])))
		else $error("read bus enable does not follow cell");

	cov_ir_load: cover property (
		@(posedge tck) disable iff (!rst_tck_n)
		sh_ir ##1 (state_ff == st_ex1_ir) ##1 upd_ir);

	cov_id_shift: cover property (
		@(posedge tck) disable iff (!rst_tck_n)
		(cap_dr && use_id) ##1 (sh_dr && use_id) [*8]);

	cov_extest_float: cover property (
		@(posedge tck) disable iff (!rst_tck_n)
		ext_tck && !bsr_upd_ff[OEC]);

	cov_reset_from_shift: cover property (
		@(posedge tck) disable iff (!rst_tck_n)
		sh_dr ##1 tms [*5] ##1 in_reset);

endmodule

// ### tb/stap_host.sv
`timescale 1ns/1ns
// far-side test controller; its clock only runs inside frames
module stap_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_out,
	input wire logic tdo_oe_n
);
	logic last_ff;
	// mode select idles high as the pad pull-up would leave it
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		last_ff = 1'b0;
	end
	// drive just after the fall, sample just before the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#23;
		// released line toggles so a stale level never passes as data
		o = (tdo_oe_n === 1'b0) ? tdo_out : ~last_ff;
		last_ff = o;
		tck = 1'b1;
		#24;
		tck = 1'b0;
		#1;
	endtask
endmodule

// ### tb/sram_jtag_tap_boundary_scan_tb_top.sv
`timescale 1ns/1ns
`include "stap_params.svh"
module sram_jtag_tap_boundary_scan_tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo_out;
	logic tdo_oe_n;
	logic ext_drive;
	logic qbus_oe;
	logic [63:0] pin_ring_in = '0;
	logic [63:0] ext_data;
	logic [2:0] ir_cur;
	logic [63:0] preload;
	int fails = 0;
	int check_count = 0;
	int q_ops[$] = '{4, 0, 2, 1, 7, 0, 7, 2}; // no reserved codes

	always #25 clk = ~clk;

	stap_top DUT (
		.clk(clk),
		.nrst(nrst),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.tdo_out(tdo_out),
		.tdo_oe_n(tdo_oe_n),
		.pin_ring_in(pin_ring_in),
		.ext_drive(ext_drive),
		.ext_data(ext_data),
		.qbus_oe(qbus_oe)
	);

	stap_host host (
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.tdo_out(tdo_out),
		.tdo_oe_n(tdo_oe_n)
	);

	task automatic summarize();
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string name, input logic [63:0] exp,
		input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic exp_qoe();
		if (ir_cur == `STAP_OP_EXTEST)
			return preload[`STAP_OE_CELL];
		return ir_cur != `STAP_OP_SAMPLE_Z;
	endfunction

	// memory side lags the test side by a few core cycles
	task automatic mem_chk();
		repeat (8) @(posedge clk);
		chk("ext_data", preload, ext_data);
		chk("ext_drive", ir_cur == `STAP_OP_EXTEST, ext_drive);
		chk("qbus_oe", exp_qoe(), qbus_oe);
	endtask

	task automatic do_reset();
		logic o;
		@(posedge clk);
		nrst <= 1'b0;
		fork
			repeat (4) @(posedge clk);
			repeat (4) host.step(1'b1, 1'b1, o);
		join
		chk("rst_oe_n", 1, tdo_oe_n);
		chk("rst_drive", 0, ext_drive);
		chk("rst_qbus", 1, qbus_oe);
		chk("rst_data", 64'h1 << `STAP_OE_CELL, ext_data);
		@(posedge clk);
		nrst <= 1'b1;
		repeat (6) host.step(1'b1, 1'b1, o);
		host.step(1'b0, 1'b1, o);
		ir_cur = `STAP_OP_IDCODE;
		preload = 64'h1 << `STAP_OE_CELL;
	endtask

	// one full scan from idle back to idle
	task automatic scan(input bit ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic o;
		host.step(1'b1, 1'b0, o);
		if (ir)
			host.step(1'b1, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			host.step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		if (ir)
			chk("drive_held", ir_cur == `STAP_OP_EXTEST, ext_drive);
		host.step(1'b1, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		chk("idle_oe_n", 1, tdo_oe_n);
	endtask

	initial begin
		#1000000;
		fails++;
		summarize();
	end

	initial begin
		logic [63:0] din;
		logic [63:0] dout;
		logic [63:0] exp;
		logic o;
		int op;
		int n;
		void'($urandom(32'h61E6C722));
		do_reset();
		mem_chk();
		scan(1'b0, 32, '0, dout);
		chk("id_default", 64'(`STAP_ID_CODE), dout);
		foreach (q_ops[k]) begin
			op = q_ops[k];
			@(posedge clk);
			pin_ring_in <= {$urandom, $urandom};
			scan(1'b1, 3, 64'(op), dout);
			chk("ir_capture", 3'h1, dout);
			ir_cur = op[2:0];
			mem_chk();
			din = {$urandom, $urandom};
			if (op == 1) begin
				n = 32;
				exp = 64'(`STAP_ID_CODE);
			end else if (op == 0 || op == 2 || op == 4) begin
				n = `STAP_BSR_LEN;
				exp = pin_ring_in;
			end else begin
				n = 8;
				exp = {56'h0, din[6:0], 1'b0};
			end
			scan(1'b0, n, din, dout);
			chk("dr_out", exp, dout);
			if (n == `STAP_BSR_LEN)
				preload = din;
			mem_chk();
		end
		// controller reset forced from inside a data shift
		host.step(1'b1, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		repeat (5) host.step(1'b1, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		ir_cur = `STAP_OP_IDCODE;
		// controller reset reloads the whole update word, cell 47 high
		preload = 64'h1 << `STAP_OE_CELL;
		mem_chk();
		scan(1'b0, 32, din, dout);
		chk("id_after_tlr", 64'(`STAP_ID_CODE), dout);
		do_reset();
		mem_chk();
		summarize();
	end
endmodule
